// ===== sdm_core.sv
// SDRAM module core: mode setting, bursts, read latency, presence detect
`timescale 1ns/1ps
module sdm_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_select_inputs,
  input wire logic [11:0] row_address_inputs,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic [3:0] bank_open,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] presence_address_straps
);
  // Block mask of the low column bits that move during a burst
  function automatic logic [9:0] blk_mask(input logic [2:0] bl, input logic ilv);
    unique case (bl)
      sdm_pkg::BL_2: blk_mask = 10'h001;
      sdm_pkg::BL_4: blk_mask = 10'h003;
      sdm_pkg::BL_8: blk_mask = 10'h007;
      // Page is refused with interleaved order and falls back to one
      sdm_pkg::BL_PAGE: blk_mask = ilv ? 10'h000 : 10'h3FF;
      default: blk_mask = 10'h000;
    endcase
  endfunction

  // Column of beat n: high bits fixed, low bits move inside the block
  function automatic logic [9:0] beat_col(input logic [9:0] st, input logic [9:0] n,
                                          input logic [9:0] m, input logic ilv);
    logic [9:0] low;
    low = ilv ? (st ^ n) : (st + n);
    beat_col = (st & ~m) | (low & m);
  endfunction

  // Command decode, straight from the sampled pins
  logic [3:0] cmd;
  logic is_lmr, is_act, is_pre, is_rd, is_wr, is_bst, col_cmd;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign is_lmr = cmd == sdm_pkg::CMD_LMR;
  assign is_act = cmd == sdm_pkg::CMD_ACT;
  assign is_pre = cmd == sdm_pkg::CMD_PRE;
  assign is_rd = cmd == sdm_pkg::CMD_RD;
  assign is_wr = cmd == sdm_pkg::CMD_WR;
  assign is_bst = cmd == sdm_pkg::CMD_BST;
  assign col_cmd = is_rd | is_wr;

  // Operating mode setting, write only from the command pins
  logic [11:0] operating_mode_setting;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // A known value stands in for the undefined power-up content
      operating_mode_setting <= sdm_pkg::MODE_RST;
    end else if (is_lmr) begin
      operating_mode_setting <= row_address_inputs;
    end
  end

  // Mode fields
  logic [2:0] burst_length_field, read_latency_field;
  logic burst_order_bit, write_burst_mode_bit;
  assign burst_length_field = operating_mode_setting[sdm_pkg::BL_LSB +: 3];
  assign burst_order_bit = operating_mode_setting[sdm_pkg::BT_BIT];
  assign read_latency_field = operating_mode_setting[sdm_pkg::CL_LSB +: 3];
  assign write_burst_mode_bit = operating_mode_setting[sdm_pkg::WB_BIT];

  // Burst state: one burst in flight, replaced by any new column command
  logic b_act, b_wr, b_ap, b_ilv, b_page;
  logic [1:0] b_bank;
  logic [9:0] b_start, b_cnt, b_mask;
  logic [9:0] n_mask, cur_col;
  logic [1:0] cur_bank;
  logic b_last, beat_rd, beat_wr, ap_fire;
  logic [1:0] ap_bank;

  // Writes go single when the write burst bit is set
  assign n_mask = (is_wr && write_burst_mode_bit) ? 10'h000 :
                  blk_mask(burst_length_field, burst_order_bit);
  assign b_last = !b_page && (b_cnt == b_mask);
  assign cur_col = col_cmd ? row_address_inputs[9:0] :
                   beat_col(b_start, b_cnt, b_mask, b_ilv);
  assign cur_bank = col_cmd ? bank_select_inputs : b_bank;
  // A new column command or a terminate takes the place of the running beat
  assign beat_rd = is_rd || (!col_cmd && !is_bst && b_act && !b_wr);
  assign beat_wr = is_wr || (!col_cmd && !is_bst && b_act && b_wr);

  // Auto precharge fires when the last beat is done or on terminate
  always_comb begin
    ap_fire = 1'b0;
    ap_bank = b_bank;
    if (col_cmd) begin
      // Single-beat command ends its burst at once
      ap_fire = (n_mask == 10'h000) && row_address_inputs[sdm_pkg::AP_BIT];
      ap_bank = bank_select_inputs;
    end else if (b_act && b_ap) begin
      ap_fire = is_bst || b_last;
    end
  end

  // Burst sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      b_act <= 1'b0;
      b_wr <= 1'b0;
      b_ap <= 1'b0;
      b_ilv <= 1'b0;
      b_page <= 1'b0;
      b_bank <= 2'h0;
      b_start <= 10'h000;
      b_cnt <= 10'h000;
      b_mask <= 10'h000;
    end else if (col_cmd) begin
      // Beat 0 is served in the command cycle, so the count starts at one
      b_act <= n_mask != 10'h000;
      b_wr <= is_wr;
      b_ap <= row_address_inputs[sdm_pkg::AP_BIT];
      b_ilv <= burst_order_bit;
      b_page <= &n_mask;
      b_bank <= bank_select_inputs;
      b_start <= row_address_inputs[9:0];
      b_cnt <= 10'h001;
      b_mask <= n_mask;
    end else if (b_act) begin
      if (is_bst || b_last) begin
        b_act <= 1'b0;
      end else begin
        // Counter wraps at ten bits, which is the page wrap
        b_cnt <= b_cnt + 10'h001;
      end
    end
  end

  // Open-bank tracking; a command in the cycle of an auto precharge is applied after it and wins on the same bank
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open <= sdm_pkg::BANK_RST;
    end else begin
      if (ap_fire) begin
        bank_open[ap_bank] <= 1'b0;
      end
      if (is_act) begin
        bank_open[bank_select_inputs] <= 1'b1;
      end else if (is_pre && row_address_inputs[sdm_pkg::AP_BIT]) begin
        bank_open <= 4'h0;
      end else if (is_pre) begin
        bank_open[bank_select_inputs] <= 1'b0;
      end
    end
  end

  // Data array: one byte per bank and column; the row is not stored
  logic [7:0] mem [0:4095];
  always_ff @(posedge ref_clk) begin
    if (beat_wr) begin
      mem[{cur_bank, cur_col}] <= dq_in;
    end
  end

  // Read pipeline: stage one is latency two, stage two latency three
  logic [7:0] p1_d, p2_d;
  logic p1_v, p2_v, cl3;
  assign cl3 = read_latency_field == sdm_pkg::CL_3;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_v <= 1'b0;
      p2_v <= 1'b0;
      p1_d <= 8'h00;
      p2_d <= 8'h00;
    end else begin
      p1_v <= beat_rd;
      p1_d <= mem[{cur_bank, cur_col}];
      p2_v <= p1_v;
      p2_d <= p1_d;
    end
  end

  // Output drivers switch on at edge n+CL-1, data sampled at n+CL
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe <= 1'b0;
      dq_out <= 8'h00;
    end else begin
      dq_oe <= cl3 ? p2_v : p1_v;
      dq_out <= cl3 ? p2_d : p1_d;
    end
  end

  // Pin synchroniser: bit 0 clock, bit 1 data, bits 4:2 straps
  logic [4:0] s1, s2, s3, pf, pf_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 5'h1F;
      s2 <= 5'h1F;
      s3 <= 5'h1F;
      pf <= 5'h1F;
      pf_q <= 5'h1F;
    end else begin
      s1 <= {presence_address_straps, sda_in, scl_in};
      s2 <= s1;
      s3 <= s2;
      // A change counts only once stages two and three agree
      pf <= (pf & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
      pf_q <= pf;
    end
  end

  // Serial bus events from the filtered lines
  logic scl_rise, scl_fall, bus_start, bus_stop, sda_f;
  assign sda_f = pf[1];
  assign scl_rise = pf[0] && !pf_q[0];
  assign scl_fall = !pf[0] && pf_q[0];
  assign bus_start = pf[0] && pf_q[0] && pf_q[1] && !pf[1];
  assign bus_stop = pf[0] && pf_q[0] && !pf_q[1] && pf[1];

  // Presence-detect store: maker half below 128, system half above
  logic [7:0] presence_detect_store [0:255];
  sdm_pkg::sdm_i2c_e ist;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [7:0] shr, ptr, tx_byte;
  logic rnw, byte_in, push_v, push_rdy, pop_v, pop_rdy, tx_load;
  assign tx_byte = presence_detect_store[ptr];
  assign byte_in = (ist == sdm_pkg::I_RX) && scl_fall && (bit_cnt == sdm_pkg::PD_BYTE_BITS)
                   && !bus_start && !bus_stop;
  assign push_v = byte_in && (phase == 2'h2);
  assign tx_load = scl_fall && rnw && !bus_start && !bus_stop &&
                   (ist == sdm_pkg::I_ACK || ist == sdm_pkg::I_TXACK);

  // Serial slave; the line is only ever pulled low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ist <= sdm_pkg::I_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      shr <= 8'h00;
      ptr <= 8'h00;
      rnw <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      ist <= sdm_pkg::I_RX;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      ist <= sdm_pkg::I_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (ist)
        sdm_pkg::I_IDLE: begin
          sda_oe <= 1'b0;
        end
        sdm_pkg::I_RX: begin
          if (scl_rise) begin
            shr <= {shr[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_in) begin
            bit_cnt <= 4'h0;
            ist <= sdm_pkg::I_ACK;
            sda_oe <= 1'b1;
            if (phase == 2'h0) begin
              // Answer only the address set by the straps
              if (shr[7:1] != {sdm_pkg::PD_DEV_TYPE, pf[4:2]}) begin
                ist <= sdm_pkg::I_IDLE;
                sda_oe <= 1'b0;
              end
              rnw <= shr[0];
              phase <= 2'h1;
            end else if (phase == 2'h1) begin
              ptr <= shr;
              phase <= 2'h2;
            end else if (push_rdy) begin
              ptr <= ptr + 8'h01;
            end else begin
              // Buffer full: refuse the byte with no acknowledge
              ist <= sdm_pkg::I_IDLE;
              sda_oe <= 1'b0;
            end
          end
        end
        sdm_pkg::I_ACK, sdm_pkg::I_TXACK: begin
          if (scl_rise && ist == sdm_pkg::I_TXACK && sda_f) begin
            ist <= sdm_pkg::I_IDLE;
          end else if (tx_load) begin
            shr <= tx_byte;
            ptr <= ptr + 8'h01;
            sda_oe <= !tx_byte[7];
            bit_cnt <= 4'h0;
            ist <= sdm_pkg::I_TX;
          end else if (scl_fall) begin
            sda_oe <= 1'b0;
            ist <= sdm_pkg::I_RX;
          end
        end
        sdm_pkg::I_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == sdm_pkg::PD_BYTE_BITS) begin
            sda_oe <= 1'b0;
            ist <= sdm_pkg::I_TXACK;
          end else if (scl_fall) begin
            shr <= {shr[6:0], 1'b0};
            sda_oe <= !shr[6];
          end
        end
        default: begin
          ist <= sdm_pkg::I_IDLE;
        end
      endcase
    end
  end

  // Open-drain level driven is always low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Two-entry write buffer; drain stalls while a read byte is fetched
  logic [7:0] fb_a [0:sdm_pkg::FB_DEPTH-1];
  logic [7:0] fb_d [0:sdm_pkg::FB_DEPTH-1];
  logic fb_wp, fb_rp;
  logic [1:0] fb_cnt;
  assign push_rdy = fb_cnt != sdm_pkg::FB_FULL;
  assign pop_v = fb_cnt != 2'h0;
  assign pop_rdy = !tx_load;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_wp <= 1'b0;
      fb_rp <= 1'b0;
      fb_cnt <= 2'h0;
    end else begin
      if (push_v && push_rdy) begin
        fb_wp <= !fb_wp;
      end
      if (pop_v && pop_rdy) begin
        fb_rp <= !fb_rp;
      end
      fb_cnt <= fb_cnt + {1'b0, push_v && push_rdy} - {1'b0, pop_v && pop_rdy};
    end
  end

  // Buffer entries and store write; no write lock exists
  always_ff @(posedge ref_clk) begin
    if (push_v && push_rdy) begin
      fb_a[fb_wp] <= ptr;
      fb_d[fb_wp] <= shr;
    end
    if (pop_v && pop_rdy) begin
      presence_detect_store[fb_a[fb_rp]] <= fb_d[fb_rp];
    end
  end

  // Checks next to the logic above
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_MODE_LOAD: assert property (is_lmr |=> operating_mode_setting == $past(row_address_inputs)) else $error("mode not loaded");
  AST_MODE_HOLD: assert property (!is_lmr |=> $stable(operating_mode_setting)) else $error("mode changed");
  AST_CL2: assert property ((is_rd && !cl3) ##1 (!is_lmr [*2]) |-> dq_oe) else $error("latency two late");
  AST_CL3: assert property ((is_rd && cl3) ##1 (!is_lmr [*3]) |-> dq_oe) else $error("latency three late");
  AST_WRAP: assert property (b_act && !col_cmd |-> (cur_col & ~b_mask) == (b_start & ~b_mask)) else $error("left block");
  AST_LEN: assert property (b_act |-> b_cnt <= b_mask) else $error("burst too long");
  AST_START: assert property (col_cmd |=> b_start == $past(row_address_inputs[9:0])) else $error("bad start");
  AST_ACT: assert property (is_act |=> bank_open[$past(bank_select_inputs)]) else $error("bank not open");
  AST_AP: assert property (ap_fire && !is_act |=> !bank_open[$past(ap_bank)]) else $error("no precharge");
  AST_PAGE: assert property (b_act && b_page && !col_cmd && !is_bst |=> b_act) else $error("page stopped");
  COV_RD3: cover property (is_rd && cl3 ##3 dq_oe);
  COV_PAGE: cover property (b_act && b_page && b_cnt == 10'h3FF);
  COV_FULL: cover property (fb_cnt == sdm_pkg::FB_FULL);
endmodule // sdm_core

// ===== sdm_ctrl_model.sv
// Memory controller model driving the command, address and data pins
`timescale 1ns/1ps
module sdm_ctrl_model (
  input wire logic ref_clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_select_inputs,
  output logic [11:0] row_address_inputs,
  output logic [7:0] dq_in
);
  // Power-up wait of 100 us at 50 ns a clock
  localparam int PWR_WAIT = 2000;
  // Last written byte; idle data lines show its inverse, never a stale copy
  logic [7:0] last_data = 8'h00;
  // Inhibit on the command pins from time zero
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    bank_select_inputs = 2'h0;
    row_address_inputs = 12'h000;
    dq_in = 8'hFF;
  end
  // One command held for one clock, changed only at the falling edge
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [7:0] d, input logic w);
    {cs_n, ras_n, cas_n, we_n} = c;
    bank_select_inputs = b;
    row_address_inputs = a;
    if (w) begin
      last_data = d;
    end
    dq_in = w ? d : ~last_data;
    @(negedge ref_clk);
  endtask
  // Idle clocks with no-op commands
  task automatic nop(input int n);
    repeat (n) issue(4'h7, 2'h0, 12'h000, 8'h00, 1'b0);
  endtask
  // Close all banks, refresh twice, load the mode, reopen bank 1
  task automatic load_mode(input logic [9:0] m);
    issue(sdm_pkg::CMD_PRE, 2'h0, 12'h400, 8'h00, 1'b0);
    nop(2);
    repeat (2) begin
      issue(4'h1, 2'h0, 12'h000, 8'h00, 1'b0);
      nop(8);
    end
    // Reserved and operating mode bits forced to zero
    issue(sdm_pkg::CMD_LMR, 2'h0, {2'h0, m[9], 2'h0, m[6:0]}, 8'h00, 1'b0);
    nop(2);
    issue(sdm_pkg::CMD_ACT, 2'h1, 12'h123, 8'h00, 1'b0);
    nop(2);
  endtask
  // Only no-ops during the power-up wait, then the first mode load
  task automatic init_seq(input logic [9:0] m);
    nop(PWR_WAIT);
    load_mode(m);
  endtask
endmodule // sdm_ctrl_model

// ===== sdm_pkg.sv
// Constants and types shared by the SDRAM module core
package sdm_pkg;
  // Command codes as {chip select, row strobe, column strobe, write enable}
  typedef enum logic [3:0] {
    CMD_LMR = 4'h0,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_BST = 4'h6
  } sdm_cmd_e;
  // Field positions inside the operating mode setting
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int OM_LSB = 7;
  localparam int WB_BIT = 9;
  // Address bit that asks for auto precharge or all-bank precharge
  localparam int AP_BIT = 10;
  // Burst length codes
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // Read latency code for three clocks; any other code runs at two
  localparam logic [2:0] CL_3 = 3'h3;
  // Values after reset
  localparam logic [11:0] MODE_RST = 12'h020;
  localparam logic [3:0] BANK_RST = 4'h0;
  // Fixed upper nibble of the presence-detect slave address
  localparam logic [3:0] PD_DEV_TYPE = 4'hA;
  // Bits in one serial byte
  localparam logic [3:0] PD_BYTE_BITS = 4'h8;
  // Two-entry buffer on the presence-detect write path
  localparam int FB_DEPTH = 2;
  localparam logic [1:0] FB_FULL = 2'h2;
  // Serial slave states
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_RX = 3'h1,
    I_ACK = 3'h2,
    I_TX = 3'h3,
    I_TXACK = 3'h4
  } sdm_i2c_e;
endpackage

// ===== testbench.sv
// Self-checking testbench for the SDRAM module core
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_in = 1'b1;
  // High while the bench master pulls the serial data line low
  logic tb_sda_low = 1'b0;
  logic [2:0] presence_address_straps = 3'h5;
  logic cs_n, ras_n, cas_n, we_n;
  logic [1:0] bank_select_inputs;
  logic [11:0] row_address_inputs;
  logic [7:0] dq_in, dq_out;
  logic dq_oe, sda_out, sda_oe, sda_in;
  logic [3:0] bank_open;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // Pulled-up open-drain line: low when either party pulls
  assign sda_in = (sda_oe ? sda_out : 1'b1) & ~tb_sda_low;
  // 50 ns clock
  always #25 ref_clk = ~ref_clk;
  sdm_core sdm_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_inputs(bank_select_inputs),
    .row_address_inputs(row_address_inputs), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .bank_open(bank_open), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .presence_address_straps(presence_address_straps));
  sdm_ctrl_model sdm_ctrl_model_inst (.ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_inputs(bank_select_inputs),
    .row_address_inputs(row_address_inputs), .dq_in(dq_in));
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 5900 clocks the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  // Compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Data pattern stored at each column
  function automatic logic [7:0] pat(input logic [9:0] c);
    return c[7:0] + 8'h30;
  endfunction
  // Column of beat k; interleaved page is unsupported and runs as length 1
  function automatic logic [9:0] mask_of(input logic [2:0] bl, input logic ilv);
    case (bl)
      sdm_pkg::BL_2: return 10'h001;
      sdm_pkg::BL_4: return 10'h003;
      sdm_pkg::BL_8: return 10'h007;
      sdm_pkg::BL_PAGE: return ilv ? 10'h000 : 10'h3FF;
      default: return 10'h000;
    endcase
  endfunction
  function automatic logic [9:0] col_at(input logic [9:0] s, input logic [9:0] mask,
                                        input logic ilv, input int k);
    return (s & ~mask) | ((ilv ? (s ^ k[9:0]) : (s + k[9:0])) & mask);
  endfunction
  // Write burst on bank 1 with data on every beat
  task automatic wr_burst(input logic [9:0] s, input logic [9:0] mask, input int n);
    for (int k = 0; k < n; k++) begin
      sdm_ctrl_model_inst.issue((k == 0) ? sdm_pkg::CMD_WR : 4'h7, 2'h1, {2'h0, s},
                                pat(col_at(s, mask, 1'b0, k)), 1'b1);
    end
  endtask
  // Read burst on bank 1, each beat looked at in the cycle it stands
  task automatic rd_burst(input logic [9:0] s, input logic [2:0] bl, input logic ilv,
                          input int cl, input int beats);
    logic [9:0] mask;
    mask = mask_of(bl, ilv);
    sdm_ctrl_model_inst.issue(sdm_pkg::CMD_RD, 2'h1, {2'h0, s}, 8'h00, 1'b0);
    sdm_ctrl_model_inst.nop(cl - 2);
    check(dq_oe, 1'b0);
    sdm_ctrl_model_inst.nop(1);
    for (int k = 0; k < beats; k++) begin
      check(dq_oe, 1'b1);
      check(dq_out, pat(col_at(s, mask, ilv, k)));
      sdm_ctrl_model_inst.nop(1);
    end
  endtask
  // One serial phase, well above the pin filter delay
  task automatic ph();
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic i2c_start();
    tb_sda_low = 1'b0;
    ph();
    scl_in = 1'b1;
    ph();
    tb_sda_low = 1'b1;
    ph();
    scl_in = 1'b0;
    ph();
  endtask
  task automatic i2c_stop();
    tb_sda_low = 1'b1;
    ph();
    scl_in = 1'b1;
    ph();
    tb_sda_low = 1'b0;
    ph();
  endtask
  // Eight bits then the acknowledge bit; data moves only while the clock is low
  task automatic i2c_byte(input logic [7:0] d, input logic last, output logic [7:0] rx,
                          output logic ack);
    logic [8:0] bits;
    bits = {d, last};
    for (int i = 8; i >= 0; i--) begin
      tb_sda_low = ~bits[i];
      ph();
      scl_in = 1'b1;
      ph();
      if (i > 0) begin
        rx[i-1] = sda_in;
      end else begin
        ack = sda_in;
      end
      scl_in = 1'b0;
      ph();
    end
  endtask
  // Main sequence
  initial begin
    logic [7:0] rx;
    logic ack;
    logic [2:0] bl_tab [5];
    int cl;
    bl_tab = '{3'h0, sdm_pkg::BL_2, sdm_pkg::BL_4, sdm_pkg::BL_8, sdm_pkg::BL_PAGE};
    repeat (6) @(negedge ref_clk);
    check({dq_oe, bank_open, sda_oe, sda_out}, 12'h000);
    rst_n = 1'b1;
    sdm_ctrl_model_inst.init_seq({1'b0, 2'h0, 3'h2, 1'b0, sdm_pkg::BL_8});
    check(bank_open, 4'h2);
    wr_burst(10'h000, 10'h007, 8);
    wr_burst(10'h008, 10'h007, 8);
    sdm_ctrl_model_inst.load_mode({1'b0, 2'h0, 3'h2, 1'b0, sdm_pkg::BL_4});
    wr_burst(10'h3FE, 10'h003, 4);
    // Single-location writes: a burst would spoil columns 9 to 11
    sdm_ctrl_model_inst.load_mode({1'b1, 2'h0, 3'h2, 1'b0, sdm_pkg::BL_4});
    wr_burst(10'h008, 10'h000, 1);
    sdm_ctrl_model_inst.nop(4);
    rd_burst(10'h008, sdm_pkg::BL_4, 1'b0, 2, 4);
    // Every length with both orders and both latencies
    for (int i = 0; i < 5; i++) begin
      for (int t = 0; t < 2; t++) begin
        cl = ((i + t) % 2 == 1) ? 3 : 2;
        sdm_ctrl_model_inst.load_mode({1'b0, 2'h0, (cl == 3) ? sdm_pkg::CL_3 : 3'h2, t[0],
                                       bl_tab[i]});
        rd_burst((i == 4) ? 10'h3FE : 10'h00D, bl_tab[i], t[0], cl,
                 (i == 4) ? ((t == 1) ? 1 : 6) : (1 << i));
        if (i == 4 && t == 0) begin
          sdm_ctrl_model_inst.issue(sdm_pkg::CMD_BST, 2'h1, 12'h000, 8'h00, 1'b0);
          sdm_ctrl_model_inst.nop(4);
        end
        check(dq_oe, 1'b0);
      end
    end
    // Auto precharge closes the row only once the burst is over
    sdm_ctrl_model_inst.load_mode({1'b0, 2'h0, 3'h2, 1'b0, sdm_pkg::BL_4});
    sdm_ctrl_model_inst.issue(sdm_pkg::CMD_RD, 2'h1, 12'h404, 8'h00, 1'b0);
    check(bank_open, 4'h2);
    sdm_ctrl_model_inst.nop(6);
    check(bank_open, 4'h0);
    sdm_ctrl_model_inst.issue(sdm_pkg::CMD_ACT, 2'h2, 12'h055, 8'h00, 1'b0);
    sdm_ctrl_model_inst.issue(sdm_pkg::CMD_ACT, 2'h1, 12'h055, 8'h00, 1'b0);
    sdm_ctrl_model_inst.issue(sdm_pkg::CMD_PRE, 2'h1, 12'h000, 8'h00, 1'b0);
    check(bank_open, 4'h4);
    // Store: write across the top end, read back through the wrap
    i2c_start();
    i2c_byte({sdm_pkg::PD_DEV_TYPE, 3'h5, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    i2c_byte(8'hFF, 1'b1, rx, ack);
    i2c_byte(8'hA5, 1'b1, rx, ack);
    check(ack, 1'b0);
    i2c_byte(8'h3C, 1'b1, rx, ack);
    check(ack, 1'b0);
    i2c_stop();
    i2c_start();
    i2c_byte({sdm_pkg::PD_DEV_TYPE, 3'h5, 1'b0}, 1'b1, rx, ack);
    i2c_byte(8'hFF, 1'b1, rx, ack);
    i2c_start();
    i2c_byte({sdm_pkg::PD_DEV_TYPE, 3'h5, 1'b1}, 1'b1, rx, ack);
    i2c_byte(8'hFF, 1'b0, rx, ack);
    check(rx, 8'hA5);
    i2c_byte(8'hFF, 1'b1, rx, ack);
    check(rx, 8'h3C);
    i2c_stop();
    // Another strap setting gets no answer
    i2c_start();
    i2c_byte({sdm_pkg::PD_DEV_TYPE, 3'h2, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b1);
    i2c_stop();
    // Moving the straps moves the slave address with them
    presence_address_straps = 3'h2;
    ph();
    i2c_start();
    i2c_byte({sdm_pkg::PD_DEV_TYPE, 3'h2, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    i2c_stop();
    i2c_start();
    i2c_byte({sdm_pkg::PD_DEV_TYPE, 3'h5, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b1);
    i2c_stop();
    final_report();
  end
endmodule // testbench
